// ---- pkg/ccps_pkg.sv ----
package ccps_pkg;
  // Core clock and master clock rates
  localparam int unsigned CLK_KHZ     = 250000;
  localparam int unsigned NUM_RATES   = 13;
  localparam int unsigned RATE_KHZ [0:12] = '{
    2500, 13000, 15000, 20000, 26000, 30000, 34000,
    41000, 45000, 51000, 55000, 60000, 130000};
  localparam int unsigned RATE_W      = 4;
  localparam int unsigned DIV_W       = 8;
  localparam int unsigned WAKE_CLOCKS = 120;
  localparam int unsigned WAKE_W      = 7;

  // Mode select encoding
  localparam logic [1:0] MODE_SSER = 2'h0;
  localparam logic [1:0] MODE_MSER = 2'h1;
  localparam logic [1:0] MODE_SPAR = 2'h2;
  localparam logic [1:0] MODE_SDM  = 2'h3;

  // Register map
  localparam int unsigned ADDR_W     = 8;
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_RATE   = 8'h04;
  localparam logic [7:0]  REG_STATUS = 8'h08;
  localparam logic [7:0]  REG_ACCESS = 8'h0C;
  localparam int unsigned CTRL_W          = 4;
  localparam logic [3:0]  CTRL_RESET      = 4'h0;
  localparam int unsigned CTRL_ACTIVE_DONE = 0;
  localparam int unsigned CTRL_KEEP_PORT   = 1;
  localparam int unsigned CTRL_SECURITY    = 2;
  localparam int unsigned CTRL_WAIT_DONE   = 3;
  localparam logic [3:0]  RATE_RESET      = 4'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [7:0] {
    ST_INIT       = 8'h01,
    ST_WAIT_INIT_ERROR_N = 8'h02,
    ST_FLASH_WAIT = 8'h04,
    ST_LOAD       = 8'h08,
    ST_CRC_ERR    = 8'h10,
    ST_WAKE       = 8'h20,
    ST_USER       = 8'h40,
    ST_BLOCKED    = 8'h80
  } ccps_state_t;

  // Half period in core clocks, rounded up so the rate is never exceeded
  function automatic logic [7:0] ccps_half_cnt(input logic [3:0] idx);
    int unsigned r;
    int unsigned q;
    r = (idx < NUM_RATES) ? RATE_KHZ[idx] : RATE_KHZ[0];
    q = (CLK_KHZ + 2 * r - 1) / (2 * r);
    if (q < 1) begin
      q = 1;
    end
    return q[7:0];
  endfunction : ccps_half_cnt
endpackage : ccps_pkg

// ---- design/ccps_sync.sv ----
module ccps_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : ccps_sync

// ---- design/ccps_clkdiv.sv ----
module ccps_clkdiv (
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic [ccps_pkg::RATE_W-1:0]     rate_i,
  output logic                                 clk_o,
  output logic                                 rise_o
);
  logic [ccps_pkg::DIV_W-1:0] cnt;
  logic [ccps_pkg::DIV_W-1:0] half;
  logic [ccps_pkg::DIV_W-1:0] next_cnt;
  logic [ccps_pkg::DIV_W-1:0] next_half;
  logic                       next_clk;
  logic                       next_rise;

  always_comb begin
    next_cnt  = cnt - 1'b1;
    next_half = half;
    next_clk  = clk_o;
    next_rise = 1'b0;
    if (cnt <= 1) begin
      next_clk  = ~clk_o;
      next_rise = ~clk_o;
      next_cnt  = half;
      // New rate taken only at the end of a full period, so no runt pulse
      if (clk_o) begin
        next_half = ccps_pkg::ccps_half_cnt(rate_i); // [RULE_17]
        next_cnt  = next_half;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt    <= 8'h01;
      half   <= 8'h01;
      clk_o  <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      half   <= next_half;
      clk_o  <= next_clk;
      rise_o <= next_rise;
    end
  end
endmodule : ccps_clkdiv

// ---- design/ccps_top.sv ----
// How it works
// RULE_01 - Program request falling edge restarts configuration
// RULE_02 - Program request ignored while JTAG holds device
// RULE_03 - Mode pins pick external port or flash
// RULE_04 - Unprogrammed flash: wait for flash, request high
// RULE_05 - Init pin low during SRAM clear, then released
// RULE_06 - External low on init pin delays loading
// RULE_07 - CRC mismatch: init low, done low, no wake
// RULE_08 - Loading from flash drives init pin low always
// RULE_09 - Flash programming: init pin flags errors only
// RULE_10 - Background flash error leaves user design running
// RULE_11 - Done pin low while configuring, done bit clear
// RULE_12 - Done released or driven once conditions met
// RULE_13 - External low on done pin can hold wake
// RULE_14 - JTAG configuration: boundary cell drives done pin
// RULE_15 - Config clock pin output only in master mode
// RULE_16 - Master clock runs 120 cycles after wake
// RULE_17 - Master clock starts slow, switches without glitches
// RULE_18 - Thirteen selectable master clock rates by parameter
// RULE_19 - Port kept in user mode only with keep-port
// RULE_20 - Flash access refused in non-flash modes
// RULE_21 - SRAM readback refused in serial modes
// RULE_22 - Readback disabled by the security bit
// RULE_23 - Mode encoding: serial, master, parallel, flash
// RULE_24 - Pin inputs synchronised before any use
//
// Local design decisions: the AXI4-Lite slave port and the address map.
module ccps_top (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic [ccps_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [ccps_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [1:0]                  mode_select_i,
  input  wire logic                        program_request_n_i,
  input  wire logic                        init_error_n_i,
  output logic                             init_error_n_o,
  output logic                             init_error_n_oe_o,
  input  wire logic                        done_pin_i,
  output logic                             done_pin_o,
  output logic                             done_pin_oe_o,
  input  wire logic                        config_clock_pin_i,
  output logic                             config_clock_pin_o,
  output logic                             config_clock_pin_oe_o,
  input  wire logic                        jtag_active_i,
  input  wire logic                        done_bscan_i,
  input  wire logic                        sram_init_done_i,
  input  wire logic                        load_done_i,
  input  wire logic                        crc_error_i,
  input  wire logic                        flash_programmed_i,
  input  wire logic                        flash_prog_active_i,
  input  wire logic                        flash_error_i,
  output logic                             load_from_flash_o,
  output logic                             user_mode_o,
  output logic                             slave_clock_edge_o,
  output logic                             config_port_ok_o,
  output logic                             flash_access_ok_o,
  output logic                             readback_ok_o
);
  ccps_pkg::ccps_state_t state;
  ccps_pkg::ccps_state_t next_state;

  logic [4:0] sync_q;
  logic [1:0] mode;
  logic       prog_n;
  logic       init_error_n_in;
  logic       done_in;
  logic       config_clock_pin_in;
  logic       prog_n_d;
  logic       config_clock_pin_d;
  logic       prog_fall;
  logic       self_download_mode;
  logic       master;

  logic [ccps_pkg::CTRL_W-1:0] ctrl;
  logic [ccps_pkg::RATE_W-1:0] rate_param;
  logic [ccps_pkg::RATE_W-1:0] rate_active;
  logic [ccps_pkg::WAKE_W-1:0] wake_cnt;
  logic                        config_clock_pin_run;
  logic                        flash_err;
  logic                        direct_err;
  logic [ccps_pkg::CTRL_W-1:0] next_ctrl;
  logic [ccps_pkg::RATE_W-1:0] next_rate_param;
  logic [ccps_pkg::RATE_W-1:0] next_rate_active;
  logic [ccps_pkg::WAKE_W-1:0] next_wake_cnt;
  logic                        next_config_clock_pin_run;
  logic                        next_flash_err;
  logic                        next_direct_err;
  logic                        mclk;
  logic                        mclk_rise;

  logic        bvalid;
  logic [1:0]  bresp;
  logic        rvalid;
  logic [1:0]  rresp;
  logic [31:0] rdata;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [1:0]  next_rresp;
  logic [31:0] next_rdata;
  logic        wr_take;
  logic        rd_take;
  logic        rate_wr;

  // Every pin input passes two flops before any use [RULE_24]
  ccps_sync #(
    .W (5)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({mode_select_i, program_request_n_i, init_error_n_i,
             done_pin_i}),
    .q_o   (sync_q)
  );

  ccps_sync #(
    .W (1)
  ) u_sync_config_clock_pin (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (config_clock_pin_i),
    .q_o   (config_clock_pin_in)
  );

  ccps_clkdiv u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .rate_i (rate_active),
    .clk_o  (mclk),
    .rise_o (mclk_rise)
  );

  assign mode     = sync_q[4:3];
  assign prog_n   = sync_q[2];
  assign init_error_n_in = sync_q[1];
  assign done_in  = sync_q[0];
  assign self_download_mode      = (mode == ccps_pkg::MODE_SDM);    // [RULE_23]
  assign master   = (mode == ccps_pkg::MODE_MSER);   // [RULE_23]

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Same as the synchroniser's reset value, so no false fall
      prog_n_d <= 1'b0;
      config_clock_pin_d   <= 1'b0;
    end else begin
      prog_n_d <= prog_n;
      config_clock_pin_d   <= config_clock_pin_in;
    end
  end

  // A fall while JTAG owns the device is dropped, not remembered
  assign prog_fall = prog_n_d & ~prog_n & ~jtag_active_i; // [RULE_01] [RULE_02]

  always_comb begin
    next_state = state;
    case (state)
      ccps_pkg::ST_INIT: begin
        if (sram_init_done_i) begin
          if (self_download_mode) begin
            next_state = direct_err ? ccps_pkg::ST_BLOCKED
                       : flash_programmed_i ? ccps_pkg::ST_LOAD // [RULE_03]
                       : ccps_pkg::ST_FLASH_WAIT;
          end else if (prog_n) begin
            next_state = ccps_pkg::ST_WAIT_INIT_ERROR_N; // [RULE_05]
          end
        end
      end
      ccps_pkg::ST_WAIT_INIT_ERROR_N: begin
        if (init_error_n_in) begin
          next_state = ccps_pkg::ST_LOAD; // [RULE_06]
        end
      end
      ccps_pkg::ST_FLASH_WAIT: begin
        if (direct_err) begin
          next_state = ccps_pkg::ST_BLOCKED; // [RULE_09]
        end else if (flash_programmed_i && prog_n) begin
          next_state = ccps_pkg::ST_LOAD; // [RULE_04]
        end
      end
      ccps_pkg::ST_LOAD: begin
        if (crc_error_i) begin
          next_state = ccps_pkg::ST_CRC_ERR; // [RULE_07]
        end else if (load_done_i) begin
          next_state = ccps_pkg::ST_WAKE;
        end
      end
      ccps_pkg::ST_WAKE: begin
        if (prog_n && (self_download_mode || init_error_n_in) &&
            (!ctrl[ccps_pkg::CTRL_WAIT_DONE] || done_in)) begin
          next_state = ccps_pkg::ST_USER; // [RULE_12] [RULE_13]
        end
      end
      ccps_pkg::ST_CRC_ERR: next_state = ccps_pkg::ST_CRC_ERR;
      ccps_pkg::ST_USER:    next_state = ccps_pkg::ST_USER;
      ccps_pkg::ST_BLOCKED: next_state = ccps_pkg::ST_BLOCKED;
      default:              next_state = ccps_pkg::ST_INIT;
    endcase
    if (prog_fall) begin
      next_state = ccps_pkg::ST_INIT; // [RULE_01]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ccps_pkg::ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  // Control, rate and flash error state
  always_comb begin
    next_ctrl        = ctrl;
    next_rate_param  = rate_param;
    next_rate_active = rate_active;
    next_wake_cnt    = wake_cnt;
    next_config_clock_pin_run    = config_clock_pin_run;
    next_flash_err   = flash_err;
    next_direct_err  = direct_err;
    if (wr_take && s_axi_awaddr == ccps_pkg::REG_CTRL && s_axi_wstrb[0]) begin
      next_ctrl = s_axi_wdata[ccps_pkg::CTRL_W-1:0];
    end
    if (rate_wr) begin
      next_rate_param = s_axi_wdata[ccps_pkg::RATE_W-1:0];
    end
    // Parameter written during loading takes effect at once
    if (rate_wr && state == ccps_pkg::ST_LOAD) begin
      if (s_axi_wdata[ccps_pkg::RATE_W-1:0] < ccps_pkg::NUM_RATES) begin
        next_rate_active = s_axi_wdata[ccps_pkg::RATE_W-1:0]; // [RULE_18]
      end
    end
    if (state == ccps_pkg::ST_USER) begin
      if (mclk_rise && wake_cnt != '0) begin
        next_wake_cnt = wake_cnt - 1'b1; // [RULE_16]
      end
      if (wake_cnt == '0) begin
        next_config_clock_pin_run = 1'b0; // [RULE_16]
      end
    end
    if (flash_prog_active_i && flash_error_i) begin
      next_flash_err = 1'b1; // [RULE_09]
      if (state != ccps_pkg::ST_USER) begin
        next_direct_err = 1'b1; // [RULE_09]
      end
    end
    if (flash_prog_active_i && !flash_error_i && !flash_err) begin
      next_flash_err = 1'b0;
    end
    if (next_state == ccps_pkg::ST_INIT && state != ccps_pkg::ST_INIT) begin
      next_rate_active = ccps_pkg::RATE_RESET; // [RULE_17]
      next_wake_cnt    = ccps_pkg::WAKE_W'(ccps_pkg::WAKE_CLOCKS);
      next_config_clock_pin_run    = 1'b1; // [RULE_16]
      // An error in the same cycle still wins over the clear
      next_flash_err   = flash_prog_active_i & flash_error_i; // [RULE_09]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl        <= ccps_pkg::CTRL_RESET;
      rate_param  <= ccps_pkg::RATE_RESET;
      rate_active <= ccps_pkg::RATE_RESET;
      wake_cnt    <= ccps_pkg::WAKE_W'(ccps_pkg::WAKE_CLOCKS);
      config_clock_pin_run    <= 1'b1;
      flash_err   <= 1'b0;
      direct_err  <= 1'b0;
    end else begin
      ctrl        <= next_ctrl;
      rate_param  <= next_rate_param;
      rate_active <= next_rate_active;
      wake_cnt    <= next_wake_cnt;
      config_clock_pin_run    <= next_config_clock_pin_run;
      flash_err   <= next_flash_err;
      direct_err  <= next_direct_err;
    end
  end

  // Pin drivers; init pin only ever pulls low, done pin can drive high
  always_comb begin
    init_error_n_o    = 1'b0;
    init_error_n_oe_o = 1'b0;
    if (state == ccps_pkg::ST_INIT || state == ccps_pkg::ST_CRC_ERR) begin
      init_error_n_oe_o = 1'b1; // [RULE_05] [RULE_07]
    end
    if (self_download_mode && (state == ccps_pkg::ST_LOAD || state == ccps_pkg::ST_WAKE)) begin
      init_error_n_oe_o = 1'b1; // [RULE_08]
    end
    // Flash error only flags the pin; user state is left alone
    if (flash_prog_active_i && flash_err) begin
      init_error_n_oe_o = 1'b1; // [RULE_09] [RULE_10]
    end
  end

  always_comb begin
    done_pin_o    = 1'b0;
    done_pin_oe_o = 1'b0;
    if (jtag_active_i) begin
      done_pin_o    = done_bscan_i; // [RULE_14]
      done_pin_oe_o = 1'b1;
    end else if (state == ccps_pkg::ST_USER ||
                 (state == ccps_pkg::ST_WAKE && prog_n &&
                  (self_download_mode || init_error_n_in))) begin
      done_pin_o    = 1'b1; // [RULE_12]
      done_pin_oe_o = ctrl[ccps_pkg::CTRL_ACTIVE_DONE];
    end else begin
      done_pin_oe_o = 1'b1; // [RULE_11]
    end
  end

  // Pin stays an input outside master mode or once the run ends
  assign config_clock_pin_o    = mclk; // [RULE_15]
  assign config_clock_pin_oe_o = master & config_clock_pin_run; // [RULE_15] [RULE_16]
  assign slave_clock_edge_o    = ~master & config_clock_pin_in & ~config_clock_pin_d;
  assign load_from_flash_o     = self_download_mode & (state == ccps_pkg::ST_LOAD);
  assign user_mode_o           = (state == ccps_pkg::ST_USER);
  assign config_port_ok_o      = (state != ccps_pkg::ST_USER) |
                                 ctrl[ccps_pkg::CTRL_KEEP_PORT]; // [RULE_19]
  assign flash_access_ok_o     = self_download_mode & config_port_ok_o; // [RULE_20]
  assign readback_ok_o         = config_port_ok_o &
                                 (mode[1] == 1'b1) & // [RULE_21]
                                 ~ctrl[ccps_pkg::CTRL_SECURITY]; // [RULE_22]

  // AXI4-Lite slave: address and data taken together
  assign wr_take       = s_axi_awvalid & s_axi_wvalid & ~bvalid;
  assign rd_take       = s_axi_arvalid & ~rvalid;
  assign rate_wr       = wr_take && s_axi_awaddr == ccps_pkg::REG_RATE &&
                         s_axi_wstrb[0];
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_arready = rd_take;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rresp   = rresp;
  assign s_axi_rdata   = rdata;

  always_comb begin
    next_bvalid = bvalid & ~s_axi_bready;
    next_bresp  = bresp;
    next_rvalid = rvalid & ~s_axi_rready;
    next_rresp  = rresp;
    next_rdata  = rdata;
    if (wr_take) begin
      next_bvalid = 1'b1;
      next_bresp  = (s_axi_awaddr == ccps_pkg::REG_CTRL ||
                     s_axi_awaddr == ccps_pkg::REG_RATE)
                    ? ccps_pkg::RESP_OKAY : ccps_pkg::RESP_SLVERR;
    end
    if (rd_take) begin
      next_rvalid = 1'b1;
      next_rresp  = ccps_pkg::RESP_OKAY;
      case (s_axi_araddr)
        ccps_pkg::REG_CTRL:   next_rdata = {28'h0000000, ctrl};
        ccps_pkg::REG_RATE:   next_rdata = {20'h00000, rate_active,
                                            4'h0, rate_param};
        ccps_pkg::REG_STATUS: next_rdata = {16'h0000, direct_err, flash_err,
                                            config_clock_pin_run, jtag_active_i,
                                            mode, init_error_n_in, done_in,
                                            state};
        ccps_pkg::REG_ACCESS: next_rdata = {29'h00000000, readback_ok_o,
                                            flash_access_ok_o,
                                            config_port_ok_o};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = ccps_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid <= 1'b0;
      bresp  <= ccps_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rresp  <= ccps_pkg::RESP_OKAY;
      rdata  <= 32'h00000000;
    end else begin
      bvalid <= next_bvalid;
      bresp  <= next_bresp;
      rvalid <= next_rvalid;
      rresp  <= next_rresp;
      rdata  <= next_rdata;
    end
  end
endmodule : ccps_top

// ---- dv/ccps_assertions.sv ----
module ccps_assertions (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [1:0] mode_select_i,
  input wire logic       program_request_n_i,
  input wire logic       init_error_n_oe_o,
  input wire logic       done_pin_o,
  input wire logic       done_pin_oe_o,
  input wire logic       config_clock_pin_oe_o,
  input wire logic       jtag_active_i,
  input wire logic       done_bscan_i,
  input wire logic       flash_error_i,
  input wire logic       load_from_flash_o,
  input wire logic       user_mode_o,
  input wire logic       flash_access_ok_o,
  input wire logic       readback_ok_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Mode pins only change under reset in the bench
  chk_clk_master:
    assert property (config_clock_pin_oe_o |->
      mode_select_i == ccps_pkg::MODE_MSER) else $error("clock oe bad");
  chk_flash_init_low:
    assert property (load_from_flash_o |-> init_error_n_oe_o)
      else $error("init not low");
  chk_done_user:
    assert property (user_mode_o && !jtag_active_i |->
      !done_pin_oe_o || done_pin_o) else $error("done low in user");
  chk_jtag_done:
    assert property (jtag_active_i [*3] |->
      done_pin_oe_o && done_pin_o == done_bscan_i)
      else $error("done not from cell");
  chk_flash_refused:
    assert property (flash_access_ok_o |->
      mode_select_i == ccps_pkg::MODE_SDM) else $error("flash granted");
  chk_serial_readback:
    assert property (readback_ok_o |-> mode_select_i[1])
      else $error("readback granted");
  chk_prog_restart:
    assert property ($fell(program_request_n_i) && !jtag_active_i
      |-> ##[1:8] !user_mode_o) else $error("no restart");
  chk_jtag_ignore:
    assert property (jtag_active_i && user_mode_o &&
      $fell(program_request_n_i) |-> user_mode_o [*8])
      else $error("restart under jtag");
  chk_bg_error:
    assert property (user_mode_o && flash_error_i |=> user_mode_o)
      else $error("user lost on error");
  cover property ($rose(user_mode_o));
  cover property ($rose(load_from_flash_o));
  cover property ($fell(config_clock_pin_oe_o));
endmodule : ccps_assertions

bind ccps_top ccps_assertions u_chk (.clk_i, .rst_i, .mode_select_i,
  .program_request_n_i, .init_error_n_oe_o, .done_pin_o, .done_pin_oe_o,
  .config_clock_pin_oe_o, .jtag_active_i, .done_bscan_i, .flash_error_i,
  .load_from_flash_o, .user_mode_o, .flash_access_ok_o, .readback_ok_o);

// ---- dv/ccps_host_model.sv ----
module ccps_host_model (
  input  wire logic hold_init_i,
  input  wire logic hold_done_i,
  input  wire logic run_i,
  output logic      init_low_o,
  output logic      done_low_o,
  output logic      clk_o
);
  timeunit 1ns;
  timeprecision 100ps;
  assign init_low_o = hold_init_i; // Delays loading
  assign done_low_o = hold_done_i; // Delays wake
  initial clk_o = 1'b0;
  // Stands still between frames, 125 ns period while running
  always #62.5 clk_o = run_i ? !clk_o : 1'b0;
endmodule : ccps_host_model

// ---- dv/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic [7:0] aw = 8'h00, ar = 8'h00;
  logic [31:0] wd = 32'h0, d;
  logic [1:0] mode = 2'h0, r;
  logic prog = 1'b1, jt = 1'b0, bsc = 1'b0, sid = 1'b0, ld = 1'b0;
  logic crc = 1'b0, fp = 1'b1, fpa = 1'b0, fe = 1'b0, hi = 1'b0;
  logic hd = 1'b0, run = 1'b0, pc = 1'b0;
  wire bv, rv, awr, wr_r, arr, il, dl, mc, ii, io, io_e, dno, dno_e;
  wire co, co_e, lff, um, sce, pok, fok, rok;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire init_w = !((io_e && !io) || il);
  wire done_w = dno_e ? dno : !dl;
  wire config_clock_pin_w = co_e ? co : mc;
  int n_errors = 0, n_compared = 0, cyc = 0, nr = 0, ns = 0, n, i;
  always #2 clk = !clk;
  ccps_host_model u_host (.hold_init_i(hi), .hold_done_i(hd), .run_i(run),
    .init_low_o(il), .done_low_o(dl), .clk_o(mc));
  ccps_top dut (.clk_i(clk), .rst_i(rst), .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1), .mode_select_i(mode), .program_request_n_i(prog),
    .init_error_n_i(init_w), .init_error_n_o(io), .init_error_n_oe_o(io_e),
    .done_pin_i(done_w), .done_pin_o(dno), .done_pin_oe_o(dno_e),
    .config_clock_pin_i(config_clock_pin_w), .config_clock_pin_o(co),
    .config_clock_pin_oe_o(co_e), .jtag_active_i(jt), .done_bscan_i(bsc),
    .sram_init_done_i(sid), .load_done_i(ld), .crc_error_i(crc),
    .flash_programmed_i(fp), .flash_prog_active_i(fpa),
    .flash_error_i(fe), .load_from_flash_o(lff), .user_mode_o(um),
    .slave_clock_edge_o(sce), .config_port_ok_o(pok),
    .flash_access_ok_o(fok), .readback_ok_o(rok));
  task stop_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task wrt(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    aw <= a; wd <= v; awv <= 1'b1; wv <= 1'b1;
    do @(posedge clk); while (!awr);
    awv <= 1'b0; wv <= 1'b0;
    do @(posedge clk); while (!bv);
    chk(bresp, e);
  endtask : wrt
  task rd(input logic [7:0] a);
    ar <= a; arv <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    d = rdata; r = rresp;
  endtask : rd
  task wst(input logic [7:0] s);
    d = 32'hX;
    for (int k = 0; k < 80 && d[7:0] !== s; k++) rd(ccps_pkg::REG_STATUS);
    chk(d[7:0], s);
  endtask : wst
  task rst_mode(input logic [1:0] m);
    mode <= m; rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
  endtask : rst_mode
  task pulse_load;
    ld <= 1'b1; @(posedge clk); ld <= 1'b0;
  endtask : pulse_load
  task half;
    pc = co; n = 0;
    while (co === pc) @(posedge clk);
    pc = co;
    while (co === pc) begin @(posedge clk); n++; end
  endtask : half
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin n_errors++; stop_test; end
  end
  logic prv = 1'b0;
  always @(posedge clk) begin
    prv <= co;
    ns <= ns + int'(sce);
    if (!um) nr <= 0;
    else if (co_e && co && !prv) nr <= nr + 1;
  end
  initial begin
    rst_mode(ccps_pkg::MODE_SPAR); hi <= 1'b1; run <= 1'b1;
    rd(ccps_pkg::REG_CTRL); chk(d, 32'h0); chk(r, ccps_pkg::RESP_OKAY);
    rd(8'h10); chk(r, ccps_pkg::RESP_SLVERR); chk(d, 32'h0);
    wrt(ccps_pkg::REG_STATUS, 32'h0, ccps_pkg::RESP_SLVERR);
    wrt(ccps_pkg::REG_CTRL, 32'h8, ccps_pkg::RESP_OKAY);
    wst(8'h01); chk(io_e, 1'b1); sid <= 1'b1;
    wst(8'h02);
    chk(io_e, 1'b0);
    repeat (70) @(posedge clk);
    hi <= 1'b0; wst(8'h08); chk(32'(ns != 0), 1);
    rd(ccps_pkg::REG_ACCESS); chk(d[2:1], 2'h2);
    hd <= 1'b1; pulse_load; wst(8'h20); repeat (20) @(posedge clk);
    rd(ccps_pkg::REG_STATUS); chk(d[7:0], 8'h20);
    hd <= 1'b0; wst(8'h40); chk(done_w, 1'b1);
    chk(pok, 1'b0);
    jt <= 1'b1; bsc <= 1'b1; prog <= 1'b0; repeat (10) @(posedge clk);
    chk(dno, 1'b1); prog <= 1'b1; repeat (4) @(posedge clk);
    rd(ccps_pkg::REG_STATUS); chk(d[7:0], 8'h40);
    jt <= 1'b0; repeat (4) @(posedge clk); prog <= 1'b0;
    wst(8'h01); chk(dno_e && !dno, 1'b1); prog <= 1'b1;
    wst(8'h08); crc <= 1'b1; @(posedge clk); crc <= 1'b0;
    wst(8'h10); chk({init_w, done_w}, 2'h0);
    rst_mode(ccps_pkg::MODE_MSER); run <= 1'b0; repeat (4) @(posedge clk);
    half; chk(n, 50);
    wst(8'h08);
    for (i = 1; i < 13; i++) begin
      wrt(ccps_pkg::REG_RATE, 32'(i), ccps_pkg::RESP_OKAY);
      repeat (120) @(posedge clk);
      half; chk(n, (ccps_pkg::CLK_KHZ + 2 * ccps_pkg::RATE_KHZ[i] - 1) /
        (2 * ccps_pkg::RATE_KHZ[i]));
    end
    rd(ccps_pkg::REG_RATE); chk(d[11:8], 4'hC);
    pulse_load; wst(8'h40);
    for (i = 0; i < 3000 && co_e; i++) @(posedge clk);
    chk(nr, 120); chk(co_e, 1'b0);
    fp <= 1'b0; rst_mode(ccps_pkg::MODE_SDM); hi <= 1'b1;
    wst(8'h04); fp <= 1'b1; wst(8'h08);
    chk({lff, io_e, fok, rok}, 4'hF);
    rd(ccps_pkg::REG_ACCESS); chk(d[2:1], 2'h3);
    wrt(ccps_pkg::REG_CTRL, 32'h4, ccps_pkg::RESP_OKAY);
    rd(ccps_pkg::REG_ACCESS); chk(d[2:1], 2'h1);
    hi <= 1'b0; pulse_load; wst(8'h40);
    fpa <= 1'b1; fe <= 1'b1; @(posedge clk); fe <= 1'b0;
    repeat (4) @(posedge clk);
    chk(um, 1'b1); chk(init_w, 1'b0);
    fp <= 1'b0; prog <= 1'b0; wst(8'h04);
    fe <= 1'b1; @(posedge clk); fe <= 1'b0;
    wst(8'h80); chk(init_w, 1'b0);
    stop_test;
  end
endmodule : tb
